// ---- src/fvrr_pkg.sv ----
// What this block does
// - Base region returns one integer per value.
// - Scaled region returns ten times stored value.
// - Float region pairs carry exact IEEE value.
// - Transmitted value always derives from stored value.
// - Point stored unless input-dependent under linear input.
// - Input-dependent linear values stored as plain integers.
// - Internal use places point from linear decimal setting for integer-stored values only.
// - Linear input allows at most three decimals.
// - Temperature input allows at most one decimal.
// - Single-register integers stay within signed 16 bits.
// - Two decimal settings at 4068 and 4069, reset zero.
// - Float writes beyond display width are stored.
// - Base region rounds to nearest, halves away from zero.
// - Scaled region rounds ten times value to nearest.
// - Scaled address equals base address plus 1000.
// - Negative integers use two's complement.
package fvrr_pkg;

  localparam logic [15:0] FVRR_BASE_LO     = 16'h0000;  // 0
  localparam logic [15:0] FVRR_BASE_HI     = 16'h03e7;  // 999
  localparam logic [15:0] FVRR_SCALED_LO   = 16'h03e8;  // 1000
  localparam logic [15:0] FVRR_SCALED_HI   = 16'h07cf;  // 1999
  localparam logic [15:0] FVRR_FLOAT_LO    = 16'h1f40;  // 8000
  localparam logic [15:0] FVRR_FLOAT_HI    = 16'h270f;  // 9999
  localparam logic [15:0] FVRR_DP_TEMP     = 16'h0fe4;  // 4068
  localparam logic [15:0] FVRR_DP_LINEAR   = 16'h0fe5;  // 4069
  localparam logic [15:0] FVRR_DP_RESET    = 16'h0000;
  localparam logic [15:0] FVRR_DP_MAX_LIN  = 16'h0003;
  localparam logic [15:0] FVRR_DP_MAX_TEMP = 16'h0001;
  localparam logic [15:0] FVRR_INT_MAX     = 16'h7fff;
  localparam logic [15:0] FVRR_INT_MIN     = 16'h8000;
  localparam logic [31:0] FVRR_FLOAT_ZERO  = 32'h0000_0000;
  localparam int          FVRR_FLOAT_BIAS  = 127;
  localparam int          FVRR_MANT_BITS   = 23;

  typedef enum logic [1:0] {
    FVRR_REGION_BASE,
    FVRR_REGION_SCALED,
    FVRR_REGION_FLOAT,
    FVRR_REGION_OTHER
  } fvrr_region_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [31:0] wdata;
  } fvrr_req_s;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [31:0] rdata;
  } fvrr_resp_s;

  typedef struct packed {
    logic [31:0] value;
    logic [1:0]  point_pos;
  } fvrr_use_s;

endpackage : fvrr_pkg

// ---- src/fvrr_regions.sv ----
`timescale 1ns/1ns
module fvrr_regions
  import fvrr_pkg::*;
#(
  parameter int                  NUM_PARAMS = 16,
  parameter logic [NUM_PARAMS-1:0] DEP_MASK = '1
) (
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  input  wire fvrr_req_s                     req,
  output fvrr_resp_s                         resp,
  input  wire logic                          input_linear,
  input  wire logic [$clog2(NUM_PARAMS)-1:0] use_index,
  output fvrr_use_s                          use_value
);

  localparam int IW = $clog2(NUM_PARAMS);

  typedef struct packed {
    logic [NUM_PARAMS-1:0][31:0] store;
    logic [15:0]                 dp_temp;
    logic [15:0]                 dp_lin;
    fvrr_resp_s                  resp;
    fvrr_use_s                   use_out;
  } fvrr_state_s;

  fvrr_state_s state;
  fvrr_state_s next_state;

  // Stored float to saturated 16-bit integer, rounded to nearest with halves
  // away from zero. Optionally the value is multiplied by ten first; the
  // product of the 24-bit significand by ten is exact in 28 bits.
  function automatic logic [15:0] fvrr_to_int(input logic [31:0] f, input logic x10);
    logic [27:0] m;
    logic [31:0] mag;
    int          s;
    m   = {4'h0, 1'b1, f[22:0]};
    mag = 32'h0;
    s   = FVRR_FLOAT_BIAS + FVRR_MANT_BITS - int'(f[30:23]);
    if (x10) begin
      m = 28'((m << 3) + (m << 1));
    end
    if (f[30:23] == 8'h00) begin
      mag = 32'h0;
    end else if (s <= 0) begin
      mag = 32'hffff_ffff;
    end else if (s <= 28) begin
      mag = 32'(m >> s) + {31'h0, m[s-1]};
    end
    if (f[31]) begin
      fvrr_to_int = (mag > 32'h0000_8000) ? FVRR_INT_MIN : 16'(-mag);
    end else begin
      fvrr_to_int = (mag > 32'h0000_7fff) ? FVRR_INT_MAX : mag[15:0];
    end
  endfunction : fvrr_to_int

  // Two's complement integer to float, optionally divided by ten. The
  // quotient is truncated, so a scaled write may land one unit in the last
  // place nearer zero than the exact decimal, up to five for results under 0.5;
  // this avoids a rounding divider.
  function automatic logic [31:0] fvrr_to_float(input logic [15:0] v, input logic div10);
    logic [16:0] mag;
    logic [40:0] num;
    logic [40:0] norm;
    int          p;
    mag  = v[15] ? 17'(17'h10000 - {1'b0, v}) : {1'b0, v};
    num  = {mag, 24'h0};
    p    = 0;
    if (div10) begin
      num = num / 41'd10;
    end
    for (int i = 0; i < 41; i++) begin
      if (num[i]) begin
        p = i;
      end
    end
    norm = num << (40 - p);
    if (num == 41'h0) begin
      fvrr_to_float = FVRR_FLOAT_ZERO;
    end else begin
      fvrr_to_float = {v[15], 8'(FVRR_FLOAT_BIAS - 24 + p), norm[39:17]};
    end
  endfunction : fvrr_to_float

  function automatic fvrr_region_e fvrr_region(input logic [15:0] a);
    if (a <= FVRR_BASE_HI) begin
      fvrr_region = FVRR_REGION_BASE;
    end else if (a >= FVRR_SCALED_LO && a <= FVRR_SCALED_HI) begin
      fvrr_region = FVRR_REGION_SCALED;
    end else if (a >= FVRR_FLOAT_LO && a <= FVRR_FLOAT_HI) begin
      fvrr_region = FVRR_REGION_FLOAT;
    end else begin
      fvrr_region = FVRR_REGION_OTHER;
    end
  endfunction : fvrr_region

  fvrr_region_e region;
  logic [15:0]  offset;
  logic [15:0]  index;
  logic         index_ok;
  logic         dep_linear;
  logic [31:0]  cur;
  logic [31:0]  wr_float;
  logic [31:0]  wr_store;

  always_comb begin
    region = fvrr_region(req.addr);
    unique case (region)
      FVRR_REGION_BASE:   offset = req.addr - FVRR_BASE_LO;
      FVRR_REGION_SCALED: offset = req.addr - FVRR_SCALED_LO;
      FVRR_REGION_FLOAT:  offset = req.addr - FVRR_FLOAT_LO;
      FVRR_REGION_OTHER:  offset = 16'h0;
    endcase
    // Float values occupy register pairs; only the even address opens a pair.
    index    = (region == FVRR_REGION_FLOAT) ? {1'b0, offset[15:1]} : offset;
    index_ok = (index < 16'(NUM_PARAMS))
             && !(region == FVRR_REGION_FLOAT && offset[0]);
    dep_linear = 1'b0;
    cur        = FVRR_FLOAT_ZERO;
    if (index_ok) begin
      dep_linear = DEP_MASK[index[IW-1:0]] && input_linear;
      cur        = state.store[index[IW-1:0]];
    end
    unique case (region)
      FVRR_REGION_BASE:   wr_float = fvrr_to_float(req.wdata[15:0], 1'b0);
      FVRR_REGION_SCALED: wr_float = fvrr_to_float(req.wdata[15:0], 1'b1);
      FVRR_REGION_FLOAT:  wr_float = req.wdata;
      FVRR_REGION_OTHER:  wr_float = FVRR_FLOAT_ZERO;
    endcase
    // Input-dependent values under a linear input keep no decimal point.
    if (dep_linear) begin
      wr_store = fvrr_to_float(fvrr_to_int(wr_float, 1'b0), 1'b0);
    end else begin
      wr_store = wr_float;
    end
  end

  always_comb begin
    next_state             = state;
    next_state.resp        = '0;
    next_state.resp.valid  = req.valid;
    if (req.valid) begin
      unique case (region)
        FVRR_REGION_BASE, FVRR_REGION_SCALED, FVRR_REGION_FLOAT: begin
          if (!index_ok) begin
            next_state.resp.error = 1'b1;
          end else if (req.write) begin
            // The whole 32-bit word lands in one cycle, so no half pair exists.
            next_state.store[index[IW-1:0]] = wr_store;
          end else if (region == FVRR_REGION_BASE) begin
            next_state.resp.rdata = {16'h0, fvrr_to_int(cur, 1'b0)};
          end else if (region == FVRR_REGION_SCALED) begin
            next_state.resp.rdata = {16'h0, fvrr_to_int(cur, 1'b1)};
          end else begin
            next_state.resp.rdata = cur;
          end
        end
        FVRR_REGION_OTHER: begin
          if (req.addr == FVRR_DP_TEMP) begin
            if (!req.write) begin
              next_state.resp.rdata = {16'h0, state.dp_temp};
            end else if (req.wdata[15:0] > FVRR_DP_MAX_TEMP) begin
              next_state.resp.error = 1'b1;
            end else begin
              next_state.dp_temp = req.wdata[15:0];
            end
          end else if (req.addr == FVRR_DP_LINEAR) begin
            if (!req.write) begin
              next_state.resp.rdata = {16'h0, state.dp_lin};
            end else if (req.wdata[15:0] > FVRR_DP_MAX_LIN) begin
              next_state.resp.error = 1'b1;
            end else begin
              next_state.dp_lin = req.wdata[15:0];
            end
          end else begin
            next_state.resp.error = 1'b1;
          end
        end
      endcase
    end
    // Internal users get the stored value plus where the point belongs; only
    // integer-stored linear values need the decimal setting applied.
    next_state.use_out.value = state.store[use_index];
    if (DEP_MASK[use_index] && input_linear) begin
      next_state.use_out.point_pos = state.dp_lin[1:0];
    end else begin
      next_state.use_out.point_pos = 2'h0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state         <= '0;
      state.dp_temp <= FVRR_DP_RESET;
      state.dp_lin  <= FVRR_DP_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign resp      = state.resp;
  assign use_value = state.use_out;

endmodule : fvrr_regions

// ---- test/fvrr_master.sv ----
`timescale 1ns/1ns
module fvrr_master
  import fvrr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire fvrr_resp_s resp,
  output fvrr_req_s       req
);
  initial req = '0;
  // The released bus shows inverted fields so a stale value can never pass as held.
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output fvrr_resp_s r);
    @(negedge core_clk);
    req <= '{1'b1, w, a, d};
    @(negedge core_clk);
    r = resp;
    req <= '{1'b0, ~w, ~a, ~d};
  endtask : xfer
  // Linear values go through the base region only, already scaled by the decimal count.
  task automatic put_linear(input logic [15:0] idx, input logic [15:0] digits,
                            output fvrr_resp_s r);
    xfer(1'b1, idx, {16'h0000, digits}, r);
  endtask : put_linear
endmodule : fvrr_master

// ---- test/fvrr_properties.sv ----
`timescale 1ns/1ns
module fvrr_properties
  import fvrr_pkg::*;
#(
  parameter int NUM_PARAMS = 16
) (
  input wire logic                          core_clk,
  input wire logic                          reset,
  input wire fvrr_req_s                     req,
  input wire fvrr_resp_s                    resp,
  input wire logic                          input_linear,
  input wire logic [$clog2(NUM_PARAMS)-1:0] use_index,
  input wire fvrr_use_s                     use_value
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_big(a, lim);
    req.valid && req.write && req.addr == a && req.wdata[15:0] > lim;
  endsequence
  chk_resp_pulse: assert property (req.valid |=> resp.valid)
    else $error("request without answer");
  chk_resp_quiet: assert property (!req.valid |=> !resp.valid)
    else $error("answer without request");
  chk_odd_float: assert property (req.valid && req.addr >= FVRR_FLOAT_LO
    && req.addr <= FVRR_FLOAT_HI && req.addr[0] |=> resp.error) else $error("odd pair taken");
  chk_hole_error: assert property (req.valid && req.addr > FVRR_SCALED_HI
    && req.addr < FVRR_DP_TEMP |=> resp.error) else $error("unmapped address taken");
  chk_index_range: assert property (req.valid && req.addr < FVRR_SCALED_LO
    && req.addr >= NUM_PARAMS |=> resp.error) else $error("index out of range taken");
  chk_lin_dp_max: assert property (s_big(FVRR_DP_LINEAR, FVRR_DP_MAX_LIN) |=> resp.error)
    else $error("linear decimals too large taken");
  chk_temp_dp_max: assert property (s_big(FVRR_DP_TEMP, FVRR_DP_MAX_TEMP) |=> resp.error)
    else $error("temperature decimals too large taken");
  chk_write_zero: assert property (req.valid && req.write |=> resp.rdata == '0)
    else $error("write returned data");
  chk_int_width: assert property (req.valid && !req.write && req.addr <= FVRR_SCALED_HI
    |=> resp.error || resp.rdata[31:16] == '0) else $error("integer wider than 16 bits");
  chk_point_temp: assert property (!input_linear |=> use_value.point_pos == '0)
    else $error("point moved under temperature input");
endmodule : fvrr_properties
bind fvrr_regions fvrr_properties #(.NUM_PARAMS(NUM_PARAMS)) u_props (.core_clk(core_clk),
  .reset(reset), .req(req), .resp(resp), .input_linear(input_linear),
  .use_index(use_index), .use_value(use_value));

// ---- test/test_fvrr_regions.sv ----
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t mismatch", $time); end end
module test_fvrr_regions
  import fvrr_pkg::*;
;
  logic       core_clk;
  logic       reset;
  logic       input_linear;
  logic [3:0] use_index;
  fvrr_req_s  req;
  fvrr_resp_s resp;
  fvrr_use_s  use_value;
  int         err_total;
  int         n_checks;
  // Parameter 0 is always fractional, so both ways of storing a value get exercised.
  fvrr_regions #(.NUM_PARAMS(16), .DEP_MASK(16'hfffe)) dut (.core_clk(core_clk),
    .reset(reset), .req(req), .resp(resp),
    .input_linear(input_linear), .use_index(use_index), .use_value(use_value));
  fvrr_master mst (.core_clk(core_clk), .resp(resp), .req(req));
  task automatic op(input logic w, input logic [15:0] a, input logic [31:0] d,
                    input logic e, input logic [31:0] x);
    fvrr_resp_s r;
    mst.xfer(w, a, d, r);
    `CHK({r.valid, r.error, r.rdata}, {1'b1, e, x})
  endtask : op
  task automatic t_reset_regs;
    op(1'b0, FVRR_DP_TEMP, '0, 1'b0, 32'h0000_0000);
    op(1'b0, FVRR_DP_LINEAR, '0, 1'b0, 32'h0000_0000);
  endtask : t_reset_regs
  task automatic t_float_temp;
    op(1'b1, 16'h1f4a, 32'h42f1_8000, 1'b0, '0);
    op(1'b0, 16'h1f4a, '0, 1'b0, 32'h42f1_8000);
    op(1'b0, 16'h0005, '0, 1'b0, 32'h0000_0079);
    op(1'b0, 16'h03ed, '0, 1'b0, 32'h0000_04b8);
    op(1'b1, 16'h1f42, 32'hc020_0000, 1'b0, '0);
    op(1'b0, 16'h0001, '0, 1'b0, 32'h0000_fffd);
    op(1'b1, 16'h0003, 32'h0000_fffd, 1'b0, '0);
    op(1'b0, 16'h1f46, '0, 1'b0, 32'hc040_0000);
    op(1'b1, 16'h03ec, 32'h0000_05e1, 1'b0, '0);
    op(1'b0, 16'h1f48, '0, 1'b0, 32'h4316_8000);
    op(1'b0, 16'h03ec, '0, 1'b0, 32'h0000_05e1);
  endtask : t_float_temp
  task automatic t_dp_limits;
    op(1'b1, FVRR_DP_LINEAR, 32'h0000_0004, 1'b1, '0);
    op(1'b1, FVRR_DP_TEMP, 32'h0000_0002, 1'b1, '0);
    op(1'b1, FVRR_DP_TEMP, 32'h0000_0001, 1'b0, '0);
    op(1'b1, FVRR_DP_LINEAR, 32'h0000_0003, 1'b0, '0);
    op(1'b0, FVRR_DP_LINEAR, '0, 1'b0, 32'h0000_0003);
  endtask : t_dp_limits
  task automatic t_linear;
    fvrr_resp_s r;
    input_linear = 1'b1;
    op(1'b1, 16'h1f44, 32'h42f1_8000, 1'b0, '0);
    op(1'b0, 16'h1f44, '0, 1'b0, 32'h42f2_0000);
    op(1'b1, 16'h1f40, 32'h4020_0000, 1'b0, '0);
    op(1'b0, 16'h1f40, '0, 1'b0, 32'h4020_0000);
    op(1'b0, 16'h0000, '0, 1'b0, 32'h0000_0003);
    mst.put_linear(16'h0002, 16'h1d97, r);
    `CHK(r.error, 1'b0)
    op(1'b0, 16'h1f44, '0, 1'b0, 32'h45ec_b800);
    op(1'b0, 16'h0002, '0, 1'b0, 32'h0000_1d97);
    op(1'b0, FVRR_DP_LINEAR, '0, 1'b0, 32'h0000_0003);
    use_index = 4'h2;
    repeat (2) @(negedge core_clk);
    `CHK(use_value, {32'h45ec_b800, 2'h3})
    use_index = 4'h0;
    repeat (2) @(negedge core_clk);
    `CHK(use_value, {32'h4020_0000, 2'h0})
  endtask : t_linear
  // A reset in mid-run must clear the store and both decimal settings again.
  task automatic t_reset_again;
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    `CHK(use_value, '0)
    t_reset_regs();
    op(1'b0, 16'h1f44, '0, 1'b0, 32'h0000_0000);
  endtask : t_reset_again
  task automatic t_refused;
    op(1'b0, 16'h1f43, '0, 1'b1, '0);
    op(1'b0, 16'h07d0, '0, 1'b1, '0);
    op(1'b0, 16'h0010, '0, 1'b1, '0);
  endtask : t_refused
  task automatic close_out;
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    reset = 1'b1;
    input_linear = 1'b0;
    use_index = 4'h0;
    err_total = 0;
    n_checks = 0;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    t_reset_regs();
    t_float_temp();
    t_dp_limits();
    t_refused();
    t_linear();
    t_reset_again();
    close_out();
  end
endmodule : test_fvrr_regions
